// >>> rtl/ltmw_ctrl.sv
// two-channel single-wire transceiver mode, wake and timeout control with wake report fifo
//
// Overview of operation
// - Each transceiver resets to off; off is always selectable and ignores bus wakes.
// - Normal mode is written in chip normal and stays usable in chip stop.
// - After enabling, driving starts only at the next fresh dominant transmit bit.
// - Receive-only disables the driver, keeps reception; writable in chip normal and stop.
// - Wake-capable writable in stop, sleep, restart, normal; forced on fail-safe entry.
// - Wake is falling edge, dominant past the filter time, then rising edge.
// - After a wake the receive output stays low until the mode changes or the chip enters stop, sleep or fail-safe.
// - Mode readout still shows the wake-capable code after a wake.
// - Rearm by write needs a change to another mode and back; same-mode rewrite does not.
// - Chip entry into stop, sleep or fail-safe rearms wake detection.
// - Wake in chip normal or stop pulses interrupt, sets status, lowers receive output.
// - Stop-mode wake requests watchdog enable when disabled and configured to.
// - Sleep wake requests restart and supply ramp, no interrupt, status recorded.
// - Restart wake stays; fail-safe wake requests restart and ramp; no interrupt.
// - Transmit dominant beyond timeout turns the driver off, bus stays recessive.
// - Transmit timeout sets the sticky fault flag of that transceiver.
// - Driver returns when transmit input goes recessive; mode never changes.
// - Bus dominant beyond bus timeout in normal or receive-only sets the fault flag.
// - Low-slope bit taken in chip normal only, applied on select rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "ltmw_params.svh"

module ltmw_fifo #(
	parameter int WIDTH = `LTMW_REPORT_WIDTH,
	parameter int DEPTH = `LTMW_REPORT_DEPTH
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	wire logic push;
	wire logic pop;
	assign in_ready = (count_q != (PW + 1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q];
	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		ptr_next = (p == (PW)'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= ptr_next(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= ptr_next(rd_ptr_q);
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end
endmodule

module ltmw_ctrl #(
	parameter int unsigned TX_TIMEOUT_CYC = `LTMW_TX_TIMEOUT_CYC,
	parameter int unsigned BUS_TIMEOUT_CYC = `LTMW_BUS_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] chip_mode,
	input wire logic [1:0] mode_wr,
	input wire logic [3:0] mode_wdata,
	output logic [1:0] first_transceiver_mode,
	output logic [1:0] second_transceiver_mode,
	input wire logic [1:0] transmit_input,
	output logic [1:0] receive_output_pin,
	input wire logic [1:0] bus_line_in,
	output logic [1:0] bus_line_out,
	output logic [1:0] bus_line_oe_n,
	output logic bus1_fault_flag,
	output logic bus2_fault_flag,
	input wire logic [1:0] fault_clear,
	output logic [1:0] wake_source_status,
	input wire logic [1:0] wake_status_clear,
	input wire logic watchdog_on_bus_wake,
	input wire logic watchdog_enabled,
	output logic watchdog_enable_req,
	output logic wake_int_n,
	output logic restart_req,
	output logic main_supply_rail_ramp,
	input wire logic spi_select_n,
	input wire logic low_slope_select,
	output logic low_slope_active,
	output logic wake_report_valid,
	input wire logic wake_report_ready,
	output logic [`LTMW_REPORT_WIDTH-1:0] wake_report_data
);
	localparam logic [11:0] WAKE_LIM = 12'(`LTMW_WAKE_FILTER_CYC);
	localparam logic [10:0] EN_LIM = 11'(`LTMW_ENABLE_CYC - 1);
	localparam logic [23:0] TX_LIM = 24'(TX_TIMEOUT_CYC - 1);
	localparam logic [23:0] BUS_LIM = 24'(BUS_TIMEOUT_CYC - 1);
	// pin synchronisers; logic reads the second stage, plus a third select stage for edge detection
	logic [1:0] tx_s1_q;
	logic [1:0] tx_s2_q;
	logic [1:0] bus_s1_q;
	logic [1:0] bus_s2_q;
	logic sel_s1_q;
	logic sel_s2_q;
	logic sel_prev_q;
	ltmw_pkg::ltmw_chip_type chip_prev_q;
	wire ltmw_pkg::ltmw_chip_type chip;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_s1_q <= 2'h3;
			tx_s2_q <= 2'h3;
			bus_s1_q <= 2'h3;
			bus_s2_q <= 2'h3;
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_prev_q <= 1'b1;
			chip_prev_q <= ltmw_pkg::LTMW_CHIP_INIT;
		end else begin
			tx_s1_q <= transmit_input;
			tx_s2_q <= tx_s1_q;
			bus_s1_q <= bus_line_in;
			bus_s2_q <= bus_s1_q;
			sel_s1_q <= spi_select_n;
			sel_s2_q <= sel_s1_q;
			sel_prev_q <= sel_s2_q;
			chip_prev_q <= chip;
		end
	end
	assign chip = ltmw_pkg::ltmw_chip_type'(chip_mode);
	wire logic chip_changed = (chip != chip_prev_q);
	wire logic enter_failsafe = chip_changed && (chip == ltmw_pkg::LTMW_CHIP_FAILSAFE);
	wire logic chip_rearm = chip_changed && (chip == ltmw_pkg::LTMW_CHIP_STOP ||
		chip == ltmw_pkg::LTMW_CHIP_SLEEP || chip == ltmw_pkg::LTMW_CHIP_FAILSAFE);
	// which mode codes software may write in the present chip mode
	function automatic logic mode_allowed(input ltmw_pkg::ltmw_mode_type m, input ltmw_pkg::ltmw_chip_type c);
		case (m)
			ltmw_pkg::LTMW_XCVR_OFF: mode_allowed = 1'b1;
			ltmw_pkg::LTMW_XCVR_NORMAL: mode_allowed = (c == ltmw_pkg::LTMW_CHIP_NORMAL);
			ltmw_pkg::LTMW_XCVR_RXONLY: mode_allowed = (c == ltmw_pkg::LTMW_CHIP_NORMAL ||
				c == ltmw_pkg::LTMW_CHIP_STOP);
			default: mode_allowed = (c == ltmw_pkg::LTMW_CHIP_NORMAL || c == ltmw_pkg::LTMW_CHIP_STOP ||
				c == ltmw_pkg::LTMW_CHIP_SLEEP || c == ltmw_pkg::LTMW_CHIP_RESTART);
		endcase
	endfunction
	wire logic [1:0] mode_rd [2];
	wire logic [1:0] fault_rd;
	wire logic [1:0] wake_evt;
	wire logic [1:0] pend;
	wire logic [1:0] pend_take;
	wire logic fifo_in_ready;
	for (genvar g = 0; g < 2; g++) begin : g_ch
		ltmw_pkg::ltmw_mode_type mode_q;
		ltmw_pkg::ltmw_mode_type mode_d;
		ltmw_pkg::ltmw_wake_state_type wst_q;
		ltmw_pkg::ltmw_wake_state_type wst_d;
		logic woken_q;
		logic armed_q;
		logic bus_prev_q;
		logic [11:0] wcnt_q;
		logic [10:0] en_cnt_q;
		logic en_done_q;
		logic tx_armed_q;
		logic [23:0] txlo_cnt_q;
		logic to_q;
		logic [23:0] buslo_cnt_q;
		logic fault_q;
		logic drive_q;
		logic rxo_q;
		logic pend_q;
		wire logic tx_low = !tx_s2_q[g];
		wire logic bus_low = !bus_s2_q[g];
		wire ltmw_pkg::ltmw_mode_type wr_mode = ltmw_pkg::ltmw_mode_type'(mode_wdata[g*2 +: 2]);
		wire logic wr_ok = mode_wr[g] && mode_allowed(wr_mode, chip);
		wire logic is_normal = (mode_q == ltmw_pkg::LTMW_XCVR_NORMAL);
		wire logic is_listen = is_normal || (mode_q == ltmw_pkg::LTMW_XCVR_RXONLY);
		wire logic mode_chg = (mode_d != mode_q);
		wire logic watching = (mode_q == ltmw_pkg::LTMW_XCVR_WAKE) && armed_q && !woken_q;
		wire logic tx_to_evt = is_normal && tx_low && (txlo_cnt_q == TX_LIM);
		wire logic bus_to_evt = is_listen && bus_low && (buslo_cnt_q == BUS_LIM);
		wire logic to_d = tx_low && (to_q || tx_to_evt);
		// fail-safe entry forces wake-capable over any write
		assign mode_d = enter_failsafe ? ltmw_pkg::LTMW_XCVR_WAKE : (wr_ok ? wr_mode : mode_q);
		assign wake_evt[g] = watching && (wst_q == ltmw_pkg::LTMW_WK_LONG) && !bus_low;
		always_comb begin
			wst_d = wst_q;
			case (wst_q)
				ltmw_pkg::LTMW_WK_IDLE: begin
					if (bus_low && bus_prev_q) begin
						wst_d = ltmw_pkg::LTMW_WK_FALL;
					end
				end
				ltmw_pkg::LTMW_WK_FALL: begin
					if (!bus_low) begin
						wst_d = ltmw_pkg::LTMW_WK_IDLE;
					end else if (wcnt_q == WAKE_LIM) begin
						wst_d = ltmw_pkg::LTMW_WK_LONG;
					end
				end
				default: begin
					if (!bus_low) begin
						wst_d = ltmw_pkg::LTMW_WK_IDLE;
					end
				end
			endcase
			if (!watching) begin
				wst_d = ltmw_pkg::LTMW_WK_IDLE;
			end
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				mode_q <= ltmw_pkg::LTMW_XCVR_OFF;
				wst_q <= ltmw_pkg::LTMW_WK_IDLE;
				bus_prev_q <= 1'b1;
				wcnt_q <= '0;
				woken_q <= 1'b0;
				armed_q <= 1'b0;
			end else begin
				mode_q <= mode_d;
				wst_q <= wst_d;
				bus_prev_q <= !bus_low;
				wcnt_q <= (wst_q == ltmw_pkg::LTMW_WK_FALL && wst_d == wst_q) ? wcnt_q + 1'b1 : '0;
				// mode field is untouched by a wake, so it still reads wake-capable
				if (wake_evt[g]) begin
					woken_q <= 1'b1;
				end else if (mode_chg || chip_rearm) begin
					woken_q <= 1'b0;
				end
				if (wake_evt[g]) begin
					armed_q <= 1'b0;
				end else if ((mode_chg && mode_d == ltmw_pkg::LTMW_XCVR_WAKE) || chip_rearm) begin
					armed_q <= 1'b1;
				end
			end
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				en_cnt_q <= '0;
				en_done_q <= 1'b0;
				tx_armed_q <= 1'b0;
			end else begin
				en_cnt_q <= (is_normal && !en_done_q) ? en_cnt_q + 1'b1 : '0;
				en_done_q <= is_normal && (en_done_q || en_cnt_q == EN_LIM);
				tx_armed_q <= is_normal && (tx_armed_q || (en_done_q && !tx_low));
			end
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				txlo_cnt_q <= '0;
				to_q <= 1'b0;
				buslo_cnt_q <= '0;
				fault_q <= 1'b0;
			end else begin
				txlo_cnt_q <= (is_normal && tx_low && !to_q) ? txlo_cnt_q + 1'b1 : '0;
				to_q <= to_d;
				buslo_cnt_q <= (is_listen && bus_low && !bus_to_evt) ? buslo_cnt_q + 1'b1 : '0;
				if (tx_to_evt || bus_to_evt) begin
					fault_q <= 1'b1;
				end else if (fault_clear[g]) begin
					fault_q <= 1'b0;
				end
			end
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				drive_q <= 1'b0;
				rxo_q <= 1'b1;
				pend_q <= 1'b0;
			end else begin
				drive_q <= is_normal && tx_armed_q && tx_low && !to_d;
				rxo_q <= (woken_q || wake_evt[g]) ? 1'b0 : (is_listen ? !bus_low : 1'b1);
				pend_q <= wake_evt[g] || (pend_q && !pend_take[g]);
			end
		end
		assign mode_rd[g] = mode_q;
		assign fault_rd[g] = fault_q;
		assign pend[g] = pend_q;
		assign bus_line_oe_n[g] = !drive_q;
		assign bus_line_out[g] = 1'b0;
		assign receive_output_pin[g] = rxo_q;
	end
	assign first_transceiver_mode = mode_rd[0];
	assign second_transceiver_mode = mode_rd[1];
	assign bus1_fault_flag = fault_rd[0];
	assign bus2_fault_flag = fault_rd[1];
	// chip-level reaction to a wake depends on the chip mode at the wake
	wire logic any_wake = |wake_evt;
	wire logic in_run = (chip == ltmw_pkg::LTMW_CHIP_NORMAL) || (chip == ltmw_pkg::LTMW_CHIP_STOP);
	wire logic in_down = (chip == ltmw_pkg::LTMW_CHIP_SLEEP) || (chip == ltmw_pkg::LTMW_CHIP_FAILSAFE);
	// a report waits in its channel until the fifo takes it, channel 0 first
	wire logic take_ch = !pend[0];
	assign pend_take = fifo_in_ready ? (pend[0] ? 2'h1 : {pend[1], 1'b0}) : 2'h0;
	logic [1:0] wst_status_q;
	logic int_n_q;
	logic restart_q;
	logic ramp_q;
	logic wd_req_q;
	logic lsm_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wst_status_q <= 2'h0;
			int_n_q <= 1'b1;
			restart_q <= 1'b0;
			ramp_q <= 1'b0;
			wd_req_q <= 1'b0;
			lsm_q <= 1'b0;
		end else begin
			wst_status_q <= wake_evt | (wst_status_q & ~wake_status_clear);
			int_n_q <= !(any_wake && in_run);
			restart_q <= any_wake && in_down;
			ramp_q <= any_wake && in_down;
			wd_req_q <= any_wake && (chip == ltmw_pkg::LTMW_CHIP_STOP) && !watchdog_enabled &&
				watchdog_on_bus_wake;
			if (sel_s2_q && !sel_prev_q && chip == ltmw_pkg::LTMW_CHIP_NORMAL) begin
				lsm_q <= low_slope_select;
			end
		end
	end
	assign wake_source_status = wst_status_q;
	assign wake_int_n = int_n_q;
	assign restart_req = restart_q;
	assign main_supply_rail_ramp = ramp_q;
	assign watchdog_enable_req = wd_req_q;
	assign low_slope_active = lsm_q;
	ltmw_fifo #(
		.WIDTH(`LTMW_REPORT_WIDTH),
		.DEPTH(`LTMW_REPORT_DEPTH)
	) u_report_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(|pend),
		.in_ready(fifo_in_ready),
		.in_data({take_ch, chip_mode}),
		.out_valid(wake_report_valid),
		.out_ready(wake_report_ready),
		.out_data(wake_report_data)
	);
endmodule

`default_nettype wire

// >>> rtl/ltmw_params.svh
// timing constants and field codes for the transceiver mode and wake control
`ifndef LTMW_PARAMS_SVH
`define LTMW_PARAMS_SVH

`define LTMW_CLK_PERIOD_NS 8

// mode field codes; only the wake-capable code is fixed by the device
`define LTMW_MODE_OFF 2'h0
`define LTMW_MODE_WAKE 2'h1
`define LTMW_MODE_NORMAL 2'h2
`define LTMW_MODE_RXONLY 2'h3

// least dominant time for a bus wake
`define LTMW_WAKE_FILTER_NS 30000
`define LTMW_WAKE_FILTER_CYC ((`LTMW_WAKE_FILTER_NS + `LTMW_CLK_PERIOD_NS - 1) / `LTMW_CLK_PERIOD_NS)

// enabling interval after entering normal mode
`define LTMW_ENABLE_NS 10000
`define LTMW_ENABLE_CYC ((`LTMW_ENABLE_NS + `LTMW_CLK_PERIOD_NS - 1) / `LTMW_CLK_PERIOD_NS)

// dominant timeouts for transmit input and bus line
`define LTMW_TX_TIMEOUT_NS 20000000
`define LTMW_TX_TIMEOUT_CYC ((`LTMW_TX_TIMEOUT_NS + `LTMW_CLK_PERIOD_NS - 1) / `LTMW_CLK_PERIOD_NS)
`define LTMW_BUS_TIMEOUT_NS 20000000
`define LTMW_BUS_TIMEOUT_CYC ((`LTMW_BUS_TIMEOUT_NS + `LTMW_CLK_PERIOD_NS - 1) / `LTMW_CLK_PERIOD_NS)

// wake report fifo shape
`define LTMW_REPORT_WIDTH 4
`define LTMW_REPORT_DEPTH 8

`endif

// >>> rtl/ltmw_pkg.sv
// types shared by the transceiver mode and wake control
package ltmw_pkg;

	typedef enum logic [1:0] {
		LTMW_XCVR_OFF = 2'h0,
		LTMW_XCVR_WAKE = 2'h1,
		LTMW_XCVR_NORMAL = 2'h2,
		LTMW_XCVR_RXONLY = 2'h3
	} ltmw_mode_type;

	typedef enum logic [2:0] {
		LTMW_CHIP_INIT = 3'h0,
		LTMW_CHIP_NORMAL = 3'h1,
		LTMW_CHIP_STOP = 3'h2,
		LTMW_CHIP_SLEEP = 3'h3,
		LTMW_CHIP_RESTART = 3'h4,
		LTMW_CHIP_FAILSAFE = 3'h5
	} ltmw_chip_type;

	// gray path: idle -> falling seen -> long dominant
	typedef enum logic [1:0] {
		LTMW_WK_IDLE = 2'h0,
		LTMW_WK_FALL = 2'h1,
		LTMW_WK_LONG = 2'h3
	} ltmw_wake_state_type;

endpackage

// >>> verification/ltmw_ctrl_sva.sv
// assertion checker for the transceiver mode and wake control
`timescale 1ns/1ps
`default_nettype none
module ltmw_ctrl_sva #(
	parameter int unsigned TX_TIMEOUT_CYC = 40
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] chip_mode,
	input wire logic [1:0] mode_wr,
	input wire logic [3:0] mode_wdata,
	input wire logic [1:0] first_transceiver_mode,
	input wire logic [1:0] second_transceiver_mode,
	input wire logic [1:0] receive_output_pin,
	input wire logic [1:0] bus_line_oe_n,
	input wire logic bus1_fault_flag,
	input wire logic [1:0] fault_clear,
	input wire logic [1:0] wake_source_status,
	input wire logic wake_int_n,
	input wire logic restart_req,
	input wire logic main_supply_rail_ramp,
	input wire logic wake_report_valid,
	input wire logic wake_report_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// cycles the first driver has been active without a break
	logic [31:0] drv_cnt_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			drv_cnt_q <= 32'h0;
		else
			drv_cnt_q <= bus_line_oe_n[0] ? 32'h0 : drv_cnt_q + 32'h1;
	end
	AST_RESET_OFF:
	assert property ($fell(reset) |-> first_transceiver_mode == 2'h0 && second_transceiver_mode == 2'h0 && wake_int_n)
		else $error("modes not off after reset");
	AST_OFF_IDLE:
	assert property (first_transceiver_mode == 2'h0 && $past(first_transceiver_mode) == 2'h0 |-> bus_line_oe_n[0])
		else $error("driver active while off");
	AST_RXONLY_IDLE:
	assert property (second_transceiver_mode == 2'h3 && $past(second_transceiver_mode) == 2'h3 |-> bus_line_oe_n[1])
		else $error("driver active in receive-only");
	AST_WRITE_NORMAL:
	assert property (mode_wr[0] && mode_wdata[1:0] == 2'h2 && chip_mode == 3'h1 |=> first_transceiver_mode == 2'h2)
		else $error("normal write not taken");
	AST_REFUSE_NORMAL:
	assert property (mode_wr[0] && mode_wdata[1:0] == 2'h2 && chip_mode == 3'h3 |=> $stable(first_transceiver_mode))
		else $error("normal write taken in sleep");
	AST_MODE_HOLD:
	assert property ($changed(first_transceiver_mode) |-> $past(mode_wr[0]) || $past(chip_mode) == 3'h5
		|| $past(chip_mode, 2) == 3'h5) else $error("mode changed without a write");
	AST_FAILSAFE_WAKE:
	assert property (chip_mode == 3'h5 && $past(chip_mode) != 3'h5 |-> ##[1:2]
		first_transceiver_mode == 2'h1 && second_transceiver_mode == 2'h1) else $error("fail-safe did not force wake");
	AST_INT_PULSE:
	assert property ($fell(wake_int_n) |-> ($past(chip_mode) == 3'h1 || $past(chip_mode) == 3'h2) ##1 wake_int_n)
		else $error("interrupt pulse wrong");
	AST_RESTART:
	assert property (restart_req |-> main_supply_rail_ramp && wake_int_n
		&& ($past(chip_mode) == 3'h3 || $past(chip_mode) == 3'h5)) else $error("restart request wrong");
	AST_WAKE_RX:
	assert property ($rose(wake_source_status[0]) |-> !receive_output_pin[0]) else $error("receive output not low on wake");
	AST_FAULT_STICKY:
	assert property (bus1_fault_flag && !fault_clear[0] |=> bus1_fault_flag) else $error("fault flag lost");
	AST_TX_LIMIT:
	assert property (drv_cnt_q <= TX_TIMEOUT_CYC + 1) else $error("driver kept past transmit timeout");
	COV_STOP_WAKE: cover property (!wake_int_n && chip_mode == 3'h2);
	COV_TX_TIMEOUT: cover property ($rose(bus1_fault_flag));
	COV_POP: cover property (wake_report_valid && wake_report_ready);
endmodule
bind ltmw_ctrl ltmw_ctrl_sva #(.TX_TIMEOUT_CYC(TX_TIMEOUT_CYC)) u_sva (.core_clk, .reset, .chip_mode, .mode_wr,
	.mode_wdata, .first_transceiver_mode, .second_transceiver_mode, .receive_output_pin, .bus_line_oe_n,
	.bus1_fault_flag, .fault_clear, .wake_source_status, .wake_int_n, .restart_req, .main_supply_rail_ramp,
	.wake_report_valid, .wake_report_ready);
`default_nettype wire

// >>> verification/ltmw_bus_node.sv
// other nodes on the two single-wire buses, resolved with the pull-up and the device driver
`timescale 1ns/1ps
`default_nettype none
module ltmw_bus_node (
	input wire logic [1:0] node_dominant,
	input wire logic [1:0] dev_line_out,
	input wire logic [1:0] dev_line_oe_n,
	output logic [1:0] bus_level
);
	// pull-up gives recessive when nobody pulls low
	assign bus_level = ~node_dominant & ~(~dev_line_oe_n & ~dev_line_out);
endmodule
`default_nettype wire

// >>> verification/tb_ltmw_ctrl.sv
// self-checking bench for the transceiver mode and wake control
`timescale 1ns/1ps
`default_nettype none
module tb_ltmw_ctrl;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] chip_mode = 3'h1;
	logic [1:0] mode_wr = 2'h0;
	logic [3:0] mode_wdata = 4'h0;
	logic [1:0] transmit_input = 2'h3;
	logic [1:0] node_dom = 2'h0;
	logic [1:0] fault_clear = 2'h0;
	logic [1:0] wake_status_clear = 2'h0;
	logic watchdog_on_bus_wake = 1'b0;
	logic watchdog_enabled = 1'b0;
	logic spi_select_n = 1'b1;
	logic low_slope_select = 1'b0;
	logic wake_report_ready = 1'b0;
	logic [1:0] first_transceiver_mode, second_transceiver_mode, receive_output_pin, bus_line_in;
	logic [1:0] bus_line_out, bus_line_oe_n, wake_source_status;
	logic bus1_fault_flag, bus2_fault_flag, watchdog_enable_req, wake_int_n, restart_req;
	logic main_supply_rail_ramp, low_slope_active, wake_report_valid;
	logic [3:0] wake_report_data, first_rd;
	int n_errors = 0, check_count = 0, n_int = 0, n_rst = 0, n_wd = 0, n_pop = 0, cyc = 0, b_int, b_rst;
	logic [2:0] tgt [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
	ltmw_ctrl #(.TX_TIMEOUT_CYC(40), .BUS_TIMEOUT_CYC(60)) dut (.core_clk, .reset, .chip_mode, .mode_wr, .mode_wdata,
		.first_transceiver_mode, .second_transceiver_mode, .transmit_input, .receive_output_pin, .bus_line_in,
		.bus_line_out, .bus_line_oe_n, .bus1_fault_flag, .bus2_fault_flag, .fault_clear, .wake_source_status,
		.wake_status_clear, .watchdog_on_bus_wake, .watchdog_enabled, .watchdog_enable_req, .wake_int_n,
		.restart_req, .main_supply_rail_ramp, .spi_select_n, .low_slope_select, .low_slope_active,
		.wake_report_valid, .wake_report_ready, .wake_report_data);
	ltmw_bus_node bus_model (.node_dominant(node_dom), .dev_line_out(bus_line_out), .dev_line_oe_n(bus_line_oe_n),
		.bus_level(bus_line_in));
	always #4 core_clk = ~core_clk;
	// pulses are counted mid-cycle, where registered outputs are settled
	always @(negedge core_clk) begin
		if (wake_int_n === 1'b0)
			n_int++;
		if (restart_req === 1'b1 && main_supply_rail_ramp === 1'b1)
			n_rst++;
		if (watchdog_enable_req === 1'b1)
			n_wd++;
		if (wake_report_valid === 1'b1 && wake_report_ready === 1'b1) begin
			if (n_pop == 0)
				first_rd = wake_report_data;
			n_pop++;
		end
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] m, input logic [3:0] d);
		mode_wr = m;
		mode_wdata = d;
		tick(1);
		mode_wr = 2'h0;
		tick(1);
	endtask
	task automatic wake(input logic [1:0] m);
		node_dom = m;
		tick(3800);
		node_dom = 2'h0;
		tick(8);
	endtask
	initial begin
		tick(3);
		reset = 1'b0;
		chk("modes", 8'h00, 8'({first_transceiver_mode, second_transceiver_mode}));
		chk("pins", 8'h3c, 8'({receive_output_pin, bus_line_oe_n, bus_line_out}));
		chk("faults", 8'h00, 8'({bus1_fault_flag, bus2_fault_flag, wake_source_status}));
		chk("flags", 8'h01, 8'({low_slope_active, wake_int_n}));
		wake(2'h3);
		chk("off wake", 8'h00, 8'({wake_source_status, 2'(n_int)}));
		$display("test reset and off done");
		chip_mode = 3'h3;
		tick(2);
		wr(2'h3, 4'he);
		chk("sleep wr", 8'h00, 8'({first_transceiver_mode, second_transceiver_mode}));
		chip_mode = 3'h2;
		wr(2'h2, 4'hc);
		chk("stop wr", 8'h03, 8'({first_transceiver_mode, second_transceiver_mode}));
		chip_mode = 3'h1;
		transmit_input = 2'h2;
		wr(2'h1, 4'h2);
		chk("normal wr", 8'h0b, 8'({first_transceiver_mode, second_transceiver_mode}));
		tick(1400);
		chk("early dominant", 8'h01, 8'(bus_line_oe_n[0]));
		transmit_input = 2'h3;
		tick(4);
		fault_clear = 2'h3;
		tick(1);
		fault_clear = 2'h0;
		transmit_input = 2'h2;
		tick(6);
		chk("drive", 8'h00, 8'({bus_line_oe_n[0], receive_output_pin[0]}));
		tick(50);
		chk("timeout", 8'h0e, 8'({bus_line_oe_n[0], bus1_fault_flag, first_transceiver_mode}));
		transmit_input = 2'h3;
		tick(4);
		chk("sticky", 8'h03, 8'({bus_line_oe_n[0], bus1_fault_flag}));
		transmit_input = 2'h2;
		tick(5);
		chk("redrive", 8'h00, 8'(bus_line_oe_n[0]));
		transmit_input = 2'h3;
		node_dom = 2'h2;
		tick(70);
		chk("clamp", 8'h0f, 8'({bus_line_oe_n[1], bus2_fault_flag, second_transceiver_mode}));
		chk("clamp rx", 8'h00, 8'(receive_output_pin[1]));
		node_dom = 2'h0;
		$display("test enable and timeouts done");
		low_slope_select = 1'b1;
		spi_select_n = 1'b0;
		tick(4);
		chk("slope early", 8'h00, 8'(low_slope_active));
		spi_select_n = 1'b1;
		tick(5);
		chk("slope", 8'h01, 8'(low_slope_active));
		wr(2'h3, 4'h5);
		chip_mode = 3'h2;
		watchdog_on_bus_wake = 1'b1;
		low_slope_select = 1'b0;
		spi_select_n = 1'b0;
		tick(4);
		spi_select_n = 1'b1;
		tick(5);
		chk("slope held", 8'h01, 8'(low_slope_active));
		wake(2'h1);
		chk("stop int", 8'h01, 8'(n_int));
		chk("watchdog", 8'h01, 8'(n_wd));
		chk("woken", 8'h0a, 8'({first_transceiver_mode, wake_source_status, receive_output_pin[0]}));
		wake(2'h1);
		wr(2'h1, 4'h1);
		wake(2'h1);
		chk("no rearm", 8'h02, 8'({n_int[6:0], receive_output_pin[0]}));
		chip_mode = 3'h1;
		tick(2);
		chip_mode = 3'h2;
		tick(2);
		chk("rearm rx", 8'h01, 8'(receive_output_pin[0]));
		watchdog_enabled = 1'b1;
		wake(2'h1);
		chk("rearm", 8'h02, 8'(n_int));
		chk("watchdog on", 8'h01, 8'(n_wd));
		$display("test stop wake done");
		foreach (tgt[i]) begin
			chip_mode = 3'h1;
			tick(2);
			wr(2'h3, 4'h0);
			if (tgt[i] != 3'h5)
				wr(2'h3, 4'h5);
			chip_mode = tgt[i];
			tick(4);
			chk("wake modes", 8'h05, 8'({first_transceiver_mode, second_transceiver_mode}));
			b_int = n_int;
			b_rst = n_rst;
			wake(2'h3);
			chk("int", 8'(tgt[i] < 3'h3), 8'(n_int - b_int));
			chk("restart", 8'(tgt[i] == 3'h3 || tgt[i] == 3'h5), 8'(n_rst - b_rst));
			chk("rx", 8'h00, 8'(receive_output_pin));
			$display("test wake in chip mode %0d done", tgt[i]);
		end
		wake_report_ready = 1'b1;
		tick(40);
		chk("pops", 8'h0a, 8'(n_pop));
		chk("first report", 8'h02, 8'(first_rd));
		chk("status", 8'h03, 8'(wake_source_status));
		wake_status_clear = 2'h3;
		tick(1);
		wake_status_clear = 2'h0;
		tick(1);
		chk("status clr", 8'h00, 8'(wake_source_status));
		$display("test report drain done");
		end_of_test();
	end
endmodule
`default_nettype wire
